// ===== cnmt_emcy.sv
`timescale 1ns/1ps
// ----------------------------------------
// Emergency frame builder
// ----------------------------------------
module cnmt_emcy (
	input  wire cnmt_pkg::cnmt_fault_t kind,
	input  wire logic [15:0]           alarms,
	input  wire logic [15:0]           warnings,
	input  wire logic                  comm_err,
	input  wire logic [6:0]            node_id,
	output cnmt_pkg::cnmt_frame_t      frame
);
	logic [15:0] code;  // Error code
	logic [7:0]  ereg;  // Error register

	// Fault kind to code
	always_comb
	begin
		case (kind)
			cnmt_pkg::FK_GENERIC: code = cnmt_pkg::EC_GENERIC;
			cnmt_pkg::FK_EEPROM:  code = cnmt_pkg::EC_EEPROM;
			cnmt_pkg::FK_WDOG:    code = cnmt_pkg::EC_WDOG;
			cnmt_pkg::FK_POS:     code = cnmt_pkg::EC_POS;
			cnmt_pkg::FK_INTCOMM: code = cnmt_pkg::EC_INTCOMM;
			cnmt_pkg::FK_MONITOR: code = cnmt_pkg::EC_MONITOR;
			cnmt_pkg::FK_BATT:    code = cnmt_pkg::EC_BATT;
			default:              code = cnmt_pkg::EC_NONE;
		endcase
	end

	// Register bits; vendor bit flags any specific code
	always_comb
	begin
		ereg = 8'h00;
		ereg[cnmt_pkg::ER_GENERIC] = (code != cnmt_pkg::EC_NONE);
		ereg[cnmt_pkg::ER_COMM]    = comm_err;
		ereg[cnmt_pkg::ER_MANUF]   = (code != cnmt_pkg::EC_NONE) && (code != cnmt_pkg::EC_GENERIC);
	end

	// Byte 7 left zero
	always_comb
	begin
		frame.id   = cnmt_pkg::COB_EMCY + {4'h0, node_id};
		frame.rtr  = 1'b0;
		frame.dlc  = cnmt_pkg::EMCY_DLC;
		frame.data = {8'h00, warnings[15:8], warnings[7:0], alarms[15:8], alarms[7:0],
		              ereg, code[15:8], code[7:0]};
	end
endmodule

// ===== cnmt_master.sv
`timescale 1ns/1ps
// ------------------------------
// Far-side master model
// ------------------------------
module cnmt_master (
	input  wire logic             clk,
	output cnmt_pkg::cnmt_frame_t rx_frame,
	output logic                  rx_valid,
	output logic                  tx_ready
);
	initial
	begin
		rx_valid = 1'b0;
		rx_frame = '0;
	end
	// Prompt or slow acceptance, drawn each cycle
	always @(negedge clk)
		tx_ready <= ($urandom % 3) != 0;
	// One frame for one cycle, then a scrambled idle bus
	task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] d);
		@(negedge clk);
		rx_frame = {id, rtr, dlc, d};
		rx_valid = 1'b1;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_frame = ~rx_frame;
	endtask
endmodule

// ===== cnmt_ms_timer.sv
`timescale 1ns/1ps
// ----------------------------------------
// Millisecond interval timer, auto reload
// ----------------------------------------
module cnmt_ms_timer #(
	parameter int W = 24
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         tick,
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic [W-1:0] period,
	output logic              expired
);
	logic [W-1:0] remain; // Milliseconds left
	logic         run;    // Timer armed

	// Count down; zero period leaves it idle
	always_ff @(posedge clk)
	begin
		if (rst || stop)
		begin
			run     <= 1'b0;
			remain  <= '0;
			expired <= 1'b0;
		end
		else if (start)
		begin
			run     <= (period != '0);
			remain  <= period;
			expired <= 1'b0;
		end
		else if (run && tick)
		begin
			// Reload so a silent partner keeps firing
			expired <= (remain == {{(W-1){1'b0}}, 1'b1});
			if (remain == {{(W-1){1'b0}}, 1'b1})
				remain <= period;
			else
				remain <= remain - {{(W-1){1'b0}}, 1'b1};
		end
		else
			expired <= 1'b0;
	end
endmodule

// ===== cnmt_node.sv
`timescale 1ns/1ps
// ----------------------------------------
// Network management slave of the encoder
// ----------------------------------------
module cnmt_node #(
	parameter int TICK_CYCLES = cnmt_pkg::TICK_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  rx_valid,
	input  wire cnmt_pkg::cnmt_frame_t rx_frame,
	output cnmt_pkg::cnmt_frame_t      tx_frame,
	output logic                       tx_valid,
	input  wire logic                  tx_ready,
	input  wire cnmt_pkg::cnmt_fault_req_t fault,
	input  wire cnmt_pkg::cnmt_cfg_t   cfg,
	input  wire logic                  lss_node_wr,
	input  wire logic [6:0]            lss_node_id,
	input  wire logic                  lss_baud_wr,
	input  wire logic [3:0]            lss_baud_idx,
	output cnmt_pkg::cnmt_state_t      nmt_state,
	output logic                       pdo_enable,
	output logic                       sdo_enable,
	output logic                       lss_enable,
	output logic [6:0]                 node_id,
	output logic [3:0]                 baud_idx,
	output logic                       comm_error,
	output logic                       reset_app,
	output logic                       reset_comm
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [31:0]           tick_cnt;     // Millisecond prescaler
	logic                  tick;         // One-cycle ms strobe
	logic                  guard_sel;    // Guarding chosen over heartbeat
	logic                  is_nmt;       // Command frame for us
	logic [7:0]            cmd;          // Command byte
	logic                  is_guard;     // Guard remote frame for us
	logic                  is_hb;        // Consumed heartbeat seen
	logic                  tx_take;      // Slot free this cycle
	logic                  tx_done;      // Frame handed over
	cnmt_pkg::cnmt_txk_t   tx_kind;      // Kind in the slot
	logic                  boot_pend;    // Boot-up still to send
	logic                  emcy_pend;    // Emergency waiting
	logic                  guard_pend;   // Guard reply waiting
	logic                  hb_pend;      // Heartbeat waiting
	logic                  toggle;       // Guard reply toggle bit
	logic [7:0]            state_byte;   // Current state code
	cnmt_pkg::cnmt_fault_t emcy_kind;    // Latched fault kind
	logic [15:0]           emcy_alarms;
	logic [15:0]           emcy_warn;
	cnmt_pkg::cnmt_frame_t emcy_frame;
	logic                  boot_acc;     // Boot-up accepted by bus
	logic [15:0]           prod_q;       // Last producer period
	logic                  prod_exp;
	logic                  life_exp;
	logic                  cons_exp;
	logic                  mon_fail;     // Monitor timeout this cycle
	logic [23:0]           life_ms;      // Guard time times factor

	// ----------------------------------------
	// Millisecond time base
	// ----------------------------------------

	// Free-running prescaler; long count kept as a parameter for simulation
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tick_cnt <= 32'h0000_0000;
			tick     <= 1'b0;
		end
		else if (tick_cnt == 32'(TICK_CYCLES - 1))
		begin
			tick_cnt <= 32'h0000_0000;
			tick     <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
			tick     <= 1'b0;
		end
	end

	// ----------------------------------------
	// Receive decode
	// ----------------------------------------

	// Frames come from the transceiver on this clock, so no synchroniser
	always_comb
	begin
		guard_sel = cfg.mfr_cfg[cnmt_pkg::CFG_GUARD_BIT];
		cmd       = rx_frame.data[7:0];
		is_nmt    = rx_valid && !rx_frame.rtr && (rx_frame.id == cnmt_pkg::COB_NMT)
		            && (rx_frame.dlc >= cnmt_pkg::NMT_DLC)
		            && ((rx_frame.data[15:8] == 8'h00) || (rx_frame.data[15:8] == {1'b0, node_id}));
		is_guard  = rx_valid && rx_frame.rtr
		            && (rx_frame.id == cnmt_pkg::COB_MON + {4'h0, node_id});
		is_hb     = rx_valid && !rx_frame.rtr && (rx_frame.dlc >= cnmt_pkg::MON_DLC)
		            && (rx_frame.id == cnmt_pkg::COB_MON + {4'h0, cfg.cons_node});
		tx_take   = !tx_valid || tx_ready;
		tx_done   = tx_valid && tx_ready;
		boot_acc  = tx_done && (tx_kind == cnmt_pkg::TX_BOOT);
		life_ms   = 24'(cfg.guard_ms * cfg.life_factor);
		mon_fail  = guard_sel ? life_exp : cons_exp;
	end

	// State byte on the bus
	always_comb
	begin
		case (nmt_state)
			cnmt_pkg::ST_PREOP: state_byte = cnmt_pkg::SB_PREOP;
			cnmt_pkg::ST_OPER:  state_byte = cnmt_pkg::SB_OPER;
			cnmt_pkg::ST_STOP:  state_byte = cnmt_pkg::SB_STOP;
			default:            state_byte = cnmt_pkg::SB_BOOT;
		endcase
	end

	// ----------------------------------------
	// Network state machine
	// ----------------------------------------

	// Commands are ignored until boot-up has gone out; unknown codes fall through
	always_ff @(posedge clk)
	begin
		if (rst)
			nmt_state <= cnmt_pkg::ST_INIT;
		else
		begin
			case (nmt_state)
				cnmt_pkg::ST_INIT:
					if (boot_acc)
						nmt_state <= cnmt_pkg::ST_PREOP;
				cnmt_pkg::ST_PREOP, cnmt_pkg::ST_OPER, cnmt_pkg::ST_STOP:
					if (is_nmt)
					begin
						case (cmd)
							cnmt_pkg::CMD_START:    nmt_state <= cnmt_pkg::ST_OPER;
							cnmt_pkg::CMD_STOP:     nmt_state <= cnmt_pkg::ST_STOP;
							cnmt_pkg::CMD_PREOP:    nmt_state <= cnmt_pkg::ST_PREOP;
							cnmt_pkg::CMD_RST_NODE,
							cnmt_pkg::CMD_RST_COMM: nmt_state <= cnmt_pkg::ST_INIT;
							default:                nmt_state <= nmt_state;
						endcase
					end
				default:
					nmt_state <= cnmt_pkg::ST_INIT;
			endcase
		end
	end

	// Reset pulses towards the application and the link layer
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reset_app  <= 1'b0;
			reset_comm <= 1'b0;
		end
		else
		begin
			reset_app  <= is_nmt && (nmt_state != cnmt_pkg::ST_INIT)
			              && (cmd == cnmt_pkg::CMD_RST_NODE);
			reset_comm <= is_nmt && (nmt_state != cnmt_pkg::ST_INIT)
			              && ((cmd == cnmt_pkg::CMD_RST_NODE) || (cmd == cnmt_pkg::CMD_RST_COMM));
		end
	end

	// Service gates follow the state one cycle later
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pdo_enable <= 1'b0;
			sdo_enable <= 1'b0;
			lss_enable <= 1'b0;
		end
		else
		begin
			pdo_enable <= (nmt_state == cnmt_pkg::ST_OPER);
			sdo_enable <= (nmt_state == cnmt_pkg::ST_PREOP) || (nmt_state == cnmt_pkg::ST_OPER);
			lss_enable <= (nmt_state == cnmt_pkg::ST_STOP);
		end
	end

	// ----------------------------------------
	// Layer settings
	// ----------------------------------------

	// Kept over a node reset; only a hard reset restores the factory values
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			node_id  <= cnmt_pkg::DEF_NODE_ID;
			baud_idx <= cnmt_pkg::DEF_BAUD_IDX;
		end
		else if (nmt_state == cnmt_pkg::ST_STOP)
		begin
			if (lss_node_wr && (lss_node_id != 7'h00))
				node_id <= lss_node_id;
			if (lss_baud_wr)
				baud_idx <= lss_baud_idx;
		end
	end

	// ----------------------------------------
	// Monitoring timers
	// ----------------------------------------

	// Remember producer period to restart on a change
	always_ff @(posedge clk)
	begin
		if (rst)
			prod_q <= 16'h0000;
		else
			prod_q <= cfg.prod_ms;
	end

	// Heartbeat producer, off while guarding or booting
	cnmt_ms_timer #(.W(24)) u_prod (
		.clk     (clk),
		.rst     (rst),
		.tick    (tick),
		.start   (boot_acc || (cfg.prod_ms != prod_q)),
		.stop    (guard_sel || (nmt_state == cnmt_pkg::ST_INIT)),
		.period  ({8'h00, cfg.prod_ms}),
		.expired (prod_exp)
	);

	// Life guarding, armed by the first guard request
	cnmt_ms_timer #(.W(24)) u_life (
		.clk     (clk),
		.rst     (rst),
		.tick    (tick),
		.start   (is_guard && guard_sel),
		.stop    (!guard_sel || (nmt_state == cnmt_pkg::ST_INIT)),
		.period  (life_ms),
		.expired (life_exp)
	);

	// Heartbeat consumer, armed by the first heartbeat
	cnmt_ms_timer #(.W(24)) u_cons (
		.clk     (clk),
		.rst     (rst),
		.tick    (tick),
		.start   (is_hb && !guard_sel),
		.stop    (guard_sel || (nmt_state == cnmt_pkg::ST_INIT)),
		.period  ({8'h00, cfg.cons_ms}),
		.expired (cons_exp)
	);

	// Communication error stays until communication restarts
	always_ff @(posedge clk)
	begin
		if (rst)
			comm_error <= 1'b0;
		else if (mon_fail)
			comm_error <= 1'b1;
		else if (nmt_state == cnmt_pkg::ST_INIT)
			comm_error <= 1'b0;
	end

	// ----------------------------------------
	// Emergency content
	// ----------------------------------------

	// A monitor failure while comm_error is clear outranks a core fault in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			emcy_kind   <= cnmt_pkg::FK_CLEAR;
			emcy_alarms <= 16'h0000;
			emcy_warn   <= 16'h0000;
		end
		else if (mon_fail && !comm_error)
			emcy_kind <= cnmt_pkg::FK_MONITOR;
		else if (fault.valid)
		begin
			emcy_kind   <= fault.kind;
			emcy_alarms <= fault.alarms;
			emcy_warn   <= fault.warnings;
		end
	end

	cnmt_emcy u_emcy (
		.kind     (emcy_kind),
		.alarms   (emcy_alarms),
		.warnings (emcy_warn),
		.comm_err (comm_error),
		.node_id  (node_id),
		.frame    (emcy_frame)
	);

	// ----------------------------------------
	// Transmit pending flags, set wins
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			boot_pend  <= 1'b1;
			emcy_pend  <= 1'b0;
			guard_pend <= 1'b0;
			hb_pend    <= 1'b0;
		end
		else
		begin
			if (is_nmt && (nmt_state != cnmt_pkg::ST_INIT)
			    && ((cmd == cnmt_pkg::CMD_RST_NODE) || (cmd == cnmt_pkg::CMD_RST_COMM)))
				boot_pend <= 1'b1;
			else if (tx_take && boot_pend)
				boot_pend <= 1'b0;
			// Emergency is sent one cycle after its content latches
			if (fault.valid || (mon_fail && !comm_error))
				emcy_pend <= 1'b1;
			else if (tx_take && !boot_pend && emcy_pend)
				emcy_pend <= 1'b0;
			if (is_guard && guard_sel && (nmt_state != cnmt_pkg::ST_INIT))
				guard_pend <= 1'b1;
			else if (tx_take && !boot_pend && !emcy_pend && guard_pend)
				guard_pend <= 1'b0;
			if (prod_exp && !guard_sel)
				hb_pend <= 1'b1;
			else if ((tx_take && !boot_pend && !emcy_pend && !guard_pend) || guard_sel)
				hb_pend <= 1'b0;
		end
	end

	// ----------------------------------------
	// Transmit slot
	// ----------------------------------------

	// Boot-up first, then emergency, guard reply, heartbeat
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_valid <= 1'b0;
			tx_kind  <= cnmt_pkg::TX_BOOT;
			tx_frame <= '0;
		end
		else if (tx_take)
		begin
			tx_valid      <= boot_pend || emcy_pend || guard_pend || hb_pend;
			tx_frame.id   <= cnmt_pkg::COB_MON + {4'h0, node_id};
			tx_frame.rtr  <= 1'b0;
			tx_frame.dlc  <= cnmt_pkg::MON_DLC;
			if (boot_pend)
			begin
				tx_kind       <= cnmt_pkg::TX_BOOT;
				tx_frame.data <= {56'h0, cnmt_pkg::SB_BOOT};
			end
			else if (emcy_pend)
			begin
				tx_kind  <= cnmt_pkg::TX_EMCY;
				tx_frame <= emcy_frame;
			end
			else if (guard_pend)
			begin
				tx_kind       <= cnmt_pkg::TX_GUARD;
				tx_frame.data <= {56'h0, toggle, state_byte[6:0]};
			end
			else
			begin
				tx_kind       <= cnmt_pkg::TX_HB;
				tx_frame.data <= {56'h0, state_byte};
			end
		end
	end

	// Toggle flips after each guard reply; restarts at zero with a reset
	always_ff @(posedge clk)
	begin
		if (rst || (nmt_state == cnmt_pkg::ST_INIT))
			toggle <= 1'b0;
		else if (tx_done && (tx_kind == cnmt_pkg::TX_GUARD))
			toggle <= ~toggle;
	end
endmodule

// ===== cnmt_node_props.sv
`timescale 1ns/1ps
// ------------------------------
// Port checker of the slave
// ------------------------------
module cnmt_node_props (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  rx_valid,
	input wire cnmt_pkg::cnmt_frame_t rx_frame,
	input wire cnmt_pkg::cnmt_frame_t tx_frame,
	input wire logic                  tx_valid,
	input wire logic                  tx_ready,
	input wire logic                  lss_node_wr,
	input wire cnmt_pkg::cnmt_state_t nmt_state,
	input wire logic                  pdo_enable,
	input wire logic                  sdo_enable,
	input wire logic                  lss_enable,
	input wire logic [6:0]            node_id,
	input wire logic                  reset_app,
	input wire logic                  reset_comm
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Command addressed to us, boot already done
	logic       acc;
	logic       alien;
	logic [7:0] cmd;
	logic [7:0] nd;
	assign cmd = rx_frame.data[7:0];
	assign nd = rx_frame.data[15:8];
	assign acc = rx_valid && rx_frame.id == 11'h000 && !rx_frame.rtr && rx_frame.dlc >= 4'h2
		&& (nd == 8'h00 || nd == {1'b0, node_id}) && nmt_state != cnmt_pkg::ST_INIT;
	// Command for some other node
	assign alien = rx_valid && rx_frame.id == 11'h000 && nd != 8'h00 && nd != {1'b0, node_id};
	a_start_cmd: assert property (acc && cmd == 8'h01 |=> nmt_state == cnmt_pkg::ST_OPER)
		else $error("start not taken");
	a_stop_cmd: assert property (acc && cmd == 8'h02 |=> nmt_state == cnmt_pkg::ST_STOP)
		else $error("stop not taken");
	a_preop_cmd: assert property (acc && cmd == 8'h80 |=> nmt_state == cnmt_pkg::ST_PREOP)
		else $error("pre-op not taken");
	a_reset_cmd: assert property (acc && cmd inside {8'h81, 8'h82} |=> reset_comm && reset_app == $past(cmd[0]))
		else $error("reset pulses wrong");
	a_alien_cmd: assert property (alien && nmt_state != cnmt_pkg::ST_INIT |=> $stable(nmt_state))
		else $error("foreign command acted on");
	a_pdo_gate: assert property (pdo_enable == ($past(nmt_state) == cnmt_pkg::ST_OPER))
		else $error("process data gate wrong");
	a_sdo_gate: assert property (sdo_enable == ($past(nmt_state) inside {cnmt_pkg::ST_PREOP, cnmt_pkg::ST_OPER}))
		else $error("parameter gate wrong");
	a_lss_gate: assert property (lss_enable == ($past(nmt_state) == cnmt_pkg::ST_STOP))
		else $error("layer setting gate wrong");
	a_lss_node: assert property (lss_node_wr && nmt_state != cnmt_pkg::ST_STOP |=> $stable(node_id))
		else $error("node id changed outside stop");
	a_boot_frame: assert property (tx_valid && nmt_state == cnmt_pkg::ST_INIT |->
		tx_frame.id == 11'h700 + node_id && tx_frame.dlc == 4'h1 && tx_frame.data[7:0] == 8'h00)
		else $error("boot frame wrong");
	a_emcy_shape: assert property (tx_valid && tx_frame.id == 11'h080 + node_id |->
		tx_frame.dlc == 4'h8 && tx_frame.data[63:56] == 8'h00)
		else $error("emergency shape wrong");
	// Main scenarios reached
	c_start: cover property (acc && cmd == 8'h01);
	c_emcy: cover property (tx_valid && tx_ready && tx_frame.id == 11'h080 + node_id);
	c_reset: cover property (reset_app);
endmodule

// ===== cnmt_node_tb_top.sv
`timescale 1ns/1ps
module cnmt_node_tb_top;
	// Expected frame plus mask of data bits
	typedef struct packed {
		cnmt_pkg::cnmt_frame_t f;
		logic [63:0]           m;
	} cnmt_note_t;
	logic                      clk;
	logic                      rst;
	logic                      rx_valid;
	logic                      tx_valid;
	logic                      tx_ready;
	cnmt_pkg::cnmt_frame_t     rx_frame;
	cnmt_pkg::cnmt_frame_t     tx_frame;
	cnmt_pkg::cnmt_fault_req_t fault;
	cnmt_pkg::cnmt_cfg_t       cfg;
	logic                      lss_node_wr;
	logic                      lss_baud_wr;
	logic [6:0]                lss_node_id;
	logic [3:0]                lss_baud_idx;
	cnmt_pkg::cnmt_state_t     nmt_state;
	logic                      pdo_enable;
	logic                      sdo_enable;
	logic                      lss_enable;
	logic [6:0]                node_id;
	logic [3:0]                baud_idx;
	logic                      comm_error;
	cnmt_note_t                notes[$];
	int                        failures;
	int                        n_compared;
	int                        i;
	logic [15:0]               al;
	logic [15:0]               wr;
	logic [3:0]                eb;
	logic [7:0]                codes [6] = '{8'h01, 8'h02, 8'h80, 8'h03, 8'h01, 8'h80};
	logic [7:0]                nodes [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h05, 8'h00};
	logic [1:0]                want [6] = '{2'b11, 2'b10, 2'b01, 2'b01, 2'b01, 2'b01};
	logic [15:0]               ecode [8] = '{16'h0000, 16'h1000, 16'h5530, 16'h6010, 16'h7320, 16'h7510,
		16'h8130, 16'hff00};
	cnmt_node #(.TICK_CYCLES(10)) i_dut (.clk, .rst, .rx_valid, .rx_frame, .tx_frame, .tx_valid, .tx_ready,
		.fault, .cfg, .lss_node_wr, .lss_node_id, .lss_baud_wr, .lss_baud_idx, .nmt_state, .pdo_enable,
		.sdo_enable, .lss_enable, .node_id, .baud_idx, .comm_error, .reset_app(), .reset_comm());
	cnmt_master i_mst (.clk, .rx_frame, .rx_valid, .tx_ready);
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
		n_compared++;
		if (exp !== got)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic note(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d, input logic [63:0] m);
		notes.push_back({id, 1'b0, dlc, d, m});
	endtask
	// Bounded wait until every noted frame went out
	task automatic drain;
		for (int k = 0; k < 600 && notes.size() != 0; k++)
			@(negedge clk);
		check("pending", 80'h0, 80'(notes.size()));
		repeat (2) @(negedge clk);
	endtask
	task automatic cmd(input logic [7:0] code, input logic [7:0] node);
		i_mst.send(11'h000, 1'b0, 4'h2, {48'h0, node, code});
	endtask
	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Accepted frame takes the oldest note
	always @(posedge clk)
		if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1)
		begin
			if (notes.size() == 0)
				check("spare frame", 80'h0, tx_frame);
			else
			begin
				check("frame", {notes[0].f[79:64], notes[0].f.data & notes[0].m},
					{tx_frame[79:64], tx_frame.data & notes[0].m});
				void'(notes.pop_front());
			end
		end
	// Hang guard
	initial
	begin
		repeat (30000) @(posedge clk);
		failures++;
		complete_run();
	end
	initial
	begin
		void'($urandom(24642));
		rst = 1'b1;
		{fault, cfg, lss_node_wr, lss_baud_wr, lss_node_id, lss_baud_idx} = '0;
		eb = 4'h6;
		repeat (8) @(negedge clk);
		check("factory", {node_id, baud_idx}, {7'h01, 4'h6});
		note(11'h701, 4'h1, 64'h0, '1);
		rst = 1'b0;
		drain();
		check("boot state", 80'(nmt_state), 80'h1);
		$display("boot test done");
		for (i = 0; i < 6; i++)
		begin
			cmd(codes[i], nodes[i]);
			repeat (2) @(negedge clk);
			lss_baud_idx = 4'($urandom);
			lss_node_id = (want[i] == 2'b10) ? 7'h01 : 7'h09;
			if (want[i] == 2'b10)
				eb = lss_baud_idx;
			{lss_baud_wr, lss_node_wr} = 2'b11;
			@(negedge clk);
			{lss_baud_wr, lss_node_wr} = 2'b00;
			@(negedge clk);
			check("state", 80'(nmt_state), 80'(want[i]));
			check("gates", {pdo_enable, sdo_enable, lss_enable}, {want[i] == 2'b11, want[i][0], want[i] == 2'b10});
			check("layer", {node_id, baud_idx}, {7'h01, eb});
		end
		$display("command test done");
		for (i = 0; i < 8; i++)
		begin
			al = 16'($urandom);
			wr = 16'($urandom);
			note(11'h081, 4'h8, {8'h0, wr, al, ecode[i] > 16'h1000, 6'h0, ecode[i] != 16'h0, ecode[i]}, '1);
			fault = {1'b1, 3'(i), al, wr};
			@(negedge clk);
			fault.valid = 1'b0;
			drain();
		end
		$display("emergency test done");
		cfg.mfr_cfg = 8'h20;
		cfg.guard_ms = 16'h0003;
		cfg.life_factor = 8'h01;
		note(11'h701, 4'h1, 64'h7f, '1);
		i_mst.send(11'h701, 1'b1, 4'h0, 64'h0);
		drain();
		note(11'h701, 4'h1, 64'hff, '1);
		note(11'h081, 4'h8, 64'h918130, 64'hefffff);
		i_mst.send(11'h701, 1'b1, 4'h0, 64'h0);
		drain();
		check("life guard", 80'(comm_error), 80'h1);
		$display("guarding test done");
		cfg.mfr_cfg = 8'h00;
		for (i = 0; i < 2; i++)
		begin
			note(11'h701, 4'h1, 64'h0, '1);
			cmd(8'h81 + 8'(i), 8'(i));
			drain();
			check("reinit", {nmt_state, comm_error}, 3'b010);
		end
		cmd(8'h02, 8'h00);
		cfg.prod_ms = 16'h0001;
		repeat (3) note(11'h701, 4'h1, 64'h04, '1);
		drain();
		cfg.prod_ms = 16'h0000;
		cfg.cons_ms = 16'h0003;
		cfg.cons_node = 7'h05;
		note(11'h081, 4'h8, 64'h918130, 64'hefffff);
		i_mst.send(11'h705, 1'b0, 4'h1, 64'h05);
		drain();
		check("heartbeat loss", 80'(comm_error), 80'h1);
		$display("heartbeat test done");
		complete_run();
	end
endmodule
bind cnmt_node cnmt_node_props i_props (.clk, .rst, .rx_valid, .rx_frame, .tx_frame, .tx_valid, .tx_ready,
	.lss_node_wr, .nmt_state, .pdo_enable, .sdo_enable, .lss_enable, .node_id, .reset_app, .reset_comm);

// ===== cnmt_pkg.sv
// Notes on behaviour
// - Emergency frame: 80h plus node, eight bytes
// - Emergency codes map fault kinds to values
// - Act when node field is zero or ours
// - Command 01h enters operational
// - Command 02h enters stopped
// - Command 80h enters pre-operational
// - Commands 81h/82h re-initialise, boot again
// - Boot-up frame 700h plus node, then pre-operational
// - Pre-operational: parameters yes, process data no
// - Operational: process data and parameters
// - Stopped: network management only
// - Layer settings accepted only when stopped
// - Answer each guarding remote frame with state
// - State bytes 0, 4, 5, 127
// - Missing guarding requests raise communication error
// - Config bit 5 selects guarding, else heartbeat
// - One monitor at a time, heartbeat default
// - Heartbeat sent every producer period; here the producer starts only on a period change after boot-up
// - Missing consumed heartbeat raises communication error
// - Factory node ID 1, 50 kBaud
package cnmt_pkg;

	// ----------------------------------------
	// Identifiers and frame lengths
	// ----------------------------------------
	localparam logic [10:0] COB_NMT      = 11'h000; // Command identifier
	localparam logic [10:0] COB_EMCY     = 11'h080; // Emergency base
	localparam logic [10:0] COB_MON      = 11'h700; // Boot-up, guard, heartbeat base
	localparam logic [3:0]  EMCY_DLC     = 4'h8;    // Emergency length
	localparam logic [3:0]  MON_DLC      = 4'h1;    // Monitor frame length
	localparam logic [3:0]  NMT_DLC      = 4'h2;    // Least command length

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0]  CMD_START    = 8'h01;
	localparam logic [7:0]  CMD_STOP     = 8'h02;
	localparam logic [7:0]  CMD_PREOP    = 8'h80;
	localparam logic [7:0]  CMD_RST_NODE = 8'h81;
	localparam logic [7:0]  CMD_RST_COMM = 8'h82;

	// ----------------------------------------
	// State bytes on the bus
	// ----------------------------------------
	localparam logic [7:0]  SB_BOOT      = 8'h00;
	localparam logic [7:0]  SB_STOP      = 8'h04;
	localparam logic [7:0]  SB_OPER      = 8'h05;
	localparam logic [7:0]  SB_PREOP     = 8'h7f;

	// ----------------------------------------
	// Emergency codes and error register bits
	// ----------------------------------------
	localparam logic [15:0] EC_NONE      = 16'h0000;
	localparam logic [15:0] EC_GENERIC   = 16'h1000;
	localparam logic [15:0] EC_EEPROM    = 16'h5530;
	localparam logic [15:0] EC_WDOG      = 16'h6010;
	localparam logic [15:0] EC_POS       = 16'h7320;
	localparam logic [15:0] EC_INTCOMM   = 16'h7510;
	localparam logic [15:0] EC_MONITOR   = 16'h8130;
	localparam logic [15:0] EC_BATT      = 16'hff00;
	localparam int          ER_GENERIC   = 0;
	localparam int          ER_COMM      = 4;
	localparam int          ER_MANUF     = 7;

	// ----------------------------------------
	// Configuration and defaults
	// ----------------------------------------
	localparam int          CFG_GUARD_BIT = 5;      // Bit of config object 2110h
	localparam logic [6:0]  DEF_NODE_ID  = 7'h01;
	localparam logic [3:0]  DEF_BAUD_IDX = 4'h6;    // Table index of 50 kBaud

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	localparam int          MS_NS        = 1000000; // One millisecond in ns
	localparam int          CLK_NS       = 8;       // Clock period in ns
	localparam int          TICK_CYCLES  = MS_NS / CLK_NS;

	// Network state, Gray along boot, pre-op, op, stop
	typedef enum logic [1:0] {
		ST_INIT  = 2'b00,
		ST_PREOP = 2'b01,
		ST_OPER  = 2'b11,
		ST_STOP  = 2'b10
	} cnmt_state_t;

	// Fault sources raising an emergency
	typedef enum logic [2:0] {
		FK_CLEAR   = 3'h0,
		FK_GENERIC = 3'h1,
		FK_EEPROM  = 3'h2,
		FK_WDOG    = 3'h3,
		FK_POS     = 3'h4,
		FK_INTCOMM = 3'h5,
		FK_MONITOR = 3'h6,
		FK_BATT    = 3'h7
	} cnmt_fault_t;

	// Which frame the transmit slot holds
	typedef enum logic [1:0] {
		TX_BOOT  = 2'b00,
		TX_EMCY  = 2'b01,
		TX_GUARD = 2'b11,
		TX_HB    = 2'b10
	} cnmt_txk_t;

	// CAN frame, data byte 0 in bits 7:0
	typedef struct packed {
		logic [10:0] id;
		logic        rtr;
		logic [3:0]  dlc;
		logic [63:0] data;
	} cnmt_frame_t;

	// Fault report from the encoder core
	typedef struct packed {
		logic        valid;
		cnmt_fault_t kind;
		logic [15:0] alarms;
		logic [15:0] warnings;
	} cnmt_fault_req_t;

	// Monitoring configuration
	typedef struct packed {
		logic [7:0]  mfr_cfg;
		logic [15:0] prod_ms;
		logic [15:0] cons_ms;
		logic [6:0]  cons_node;
		logic [15:0] guard_ms;
		logic [7:0]  life_factor;
	} cnmt_cfg_t;

endpackage
